// *** pkg/sspt_pkg.sv ***
/*
  Shared constants and types for the sync-output generator and the per-lane
  pseudo-random sequence test. Assumes one 40 MHz clock and a byte-wide
  register port addressed by the printed register offsets.
*/
package sspt_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [11:0] ADDR_SYNC_MASKS = 12'h311;
  localparam logic [11:0] ADDR_SYNC_DURS = 12'h312;
  localparam logic [11:0] ADDR_MF_PERIOD = 12'h313;
  localparam logic [11:0] ADDR_TEST_CLK_EN = 12'h315;
  localparam logic [11:0] ADDR_TEST_CTRL = 12'h316;
  localparam logic [11:0] ADDR_THR_LO = 12'h317;
  localparam logic [11:0] ADDR_THR_MID = 12'h318;
  localparam logic [11:0] ADDR_THR_HI = 12'h319;
  localparam logic [11:0] ADDR_CNT_LO = 12'h31a;
  localparam logic [11:0] ADDR_CNT_MID = 12'h31b;
  localparam logic [11:0] ADDR_CNT_HI = 12'h31c;
  localparam logic [11:0] ADDR_PASS = 12'h31d;

  // ==========================================================================
  // Field positions
  localparam int MASK_FRAME_BIT = 0;
  localparam int MASK_MFRAME_BIT = 2;
  localparam int ERR_DUR_LSB = 4;
  localparam int REQ_DUR_LSB = 0;
  localparam int CLEAR_BIT = 0;
  localparam int RUN_BIT = 1;
  localparam int SEQ_SEL_LSB = 2;
  localparam int LANE_SEL_LSB = 4;

  // Writable bit masks (reserved bits read back as zero)
  localparam logic [7:0] SYNC_MASKS_WMASK = 8'h07;
  localparam logic [7:0] TEST_CTRL_WMASK = 8'h7f;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [23:0] RST_THR = 24'h000000;
  localparam logic RST_PASS = 1'b1;

  // ==========================================================================
  // Geometry and timing
  localparam int LANES = 8;
  // Octets per frame of the link; plain default, set to match the link setup
  localparam int FRAME_OCTETS = 1;
  localparam int FRAMES_PER_REQ = 5;
  localparam int REQ_EXTRA_OCTETS = 9;
  // Parallel clock is mclk divided by two: half a parallel cycle is one mclk
  localparam int MCLK_PER_PCLK = 2;
  localparam int OCTETS_PER_PCLK = 4;
  localparam int PRBS_FILL = 31;

  // ==========================================================================
  // Sequence select codes
  localparam logic [1:0] SEQ_PRBS7 = 2'h0;
  localparam logic [1:0] SEQ_PRBS15 = 2'h1;
  localparam logic [1:0] SEQ_PRBS31 = 2'h2;
  localparam logic [1:0] SEQ_UNUSED = 2'h3;

  // Test state machine, one-hot
  typedef enum logic [1:0] {
    TST_IDLE = 2'b01,
    TST_RUN = 2'b10
  } sspt_tst_t;

  // Loss events from lane-deskew unit zero, carried together
  typedef struct packed {
    logic frame_loss;
    logic mframe_loss;
  } sspt_loss_t;
endpackage

// *** hw/sspt_lane_chk.sv ***
/*
  One lane of the pseudo-random sequence checker: a self-synchronising
  checker with a saturating 24-bit error count and a sticky pass flag.
  Assumes one received bit per mclk cycle from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sspt_lane_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic active,
  input wire logic [1:0] seq_sel,
  input wire logic rx_bit,
  input wire logic [23:0] thr,
  output logic [23:0] err_cnt,
  output logic pass
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic [30:0] hist;  // Last received bits, newest in bit 0
    logic [4:0] fill;   // Bits seen since start, saturates at full history
    logic [23:0] cnt;   // Error count
    logic pass;         // Cleared once the threshold is reached
  } sspt_chk_st_t;

  sspt_chk_st_t st_r;
  sspt_chk_st_t st_nxt;
  logic pred;
  logic [23:0] cnt_inc;

  // ==========================================================================
  // Next state: predict the bit from history, count misses
  always_comb begin
    st_nxt = st_r;
    pred = 1'b0;
    cnt_inc = st_r.cnt;
    unique case (seq_sel)
      sspt_pkg::SEQ_PRBS7: pred = st_r.hist[6] ^ st_r.hist[5];
      sspt_pkg::SEQ_PRBS15: pred = st_r.hist[14] ^ st_r.hist[13];
      sspt_pkg::SEQ_PRBS31: pred = st_r.hist[30] ^ st_r.hist[27];
      sspt_pkg::SEQ_UNUSED: pred = rx_bit;  // Unused code checks nothing
    endcase
    if (clear) begin
      // Clear returns the lane to a fresh start
      st_nxt.hist = '0;
      st_nxt.fill = '0;
      st_nxt.cnt = sspt_pkg::RST_THR;
      st_nxt.pass = sspt_pkg::RST_PASS;
    end else if (active) begin
      st_nxt.hist = {st_r.hist[29:0], rx_bit};
      if (st_r.fill != 5'(sspt_pkg::PRBS_FILL)) begin
        // Misses before the history is full are seeding, not errors
        st_nxt.fill = st_r.fill + 5'h01;
      end else if (pred != rx_bit) begin
        // Saturate rather than wrap so a long run never looks clean
        if (st_r.cnt != 24'hffffff) begin
          cnt_inc = st_r.cnt + 24'h000001;
        end
        st_nxt.cnt = cnt_inc;
        if (cnt_inc >= thr) begin
          st_nxt.pass = 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '{hist: 31'h0, fill: 5'h0, cnt: 24'h0, pass: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign err_cnt = st_r.cnt;
  assign pass = st_r.pass;
endmodule
`default_nettype wire

// *** hw/sspt_top.sv ***
/*
  Sync-output generator and lane pseudo-random sequence test control with
  their registers. Assumes loss events, sync requests, error reports,
  multiframe ticks and lane bits come from logic on mclk, and a byte-wide
  register port driven by the configuration interface on the same clock.
*/
// Overview of operation
// - Mask bit 2 blocks multiframe-loss sync low
// - Mask bit 0 blocks frame-loss sync low
// - Error pulse: half parallel cycle plus field
// - Request pulse: five frames, nine octets, plus
// - Report multiframe period in parallel cycles
// - Lane test clocks gated while enable clear
// - Lane select picks reported error count
// - Pattern field picks checked sequence; 11 unused
// - Run bit starts and stops the test
// - Clear bit resets test machine and counters
// - 24-bit threshold raises lane error flag
// - Selected lane count readable as three bytes
// - Per-lane pass bits, reset all ones
`timescale 1ns/1ps
`default_nettype none
module sspt_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire sspt_pkg::sspt_loss_t loss_in,
  input wire logic sync_req,
  input wire logic err_report,
  input wire logic lmfc_tick,
  input wire logic [7:0] lane_bits,
  output logic sync_out_n,
  output logic [7:0] lane_test_clk_en
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0] masks;      // Sync loss masks
    logic [7:0] durs;       // Pulse lengths
    logic [7:0] clk_en;     // Lane test clock enables
    logic [7:0] ctrl;       // Lane test control
    logic [23:0] thr;       // Error threshold
    sspt_pkg::sspt_tst_t tst;
    logic pclk_ph;          // Parallel clock phase divider
    logic [7:0] mf_cnt;     // Parallel cycles since last multiframe tick
    logic [7:0] mf_period;  // Last measured multiframe period
    logic [7:0] pulse;      // mclk cycles of sync low still owed
    logic sync_n;
    logic [7:0] rdata;
    logic [7:0] ungate;
  } sspt_st_t;

  sspt_st_t st_r;
  sspt_st_t st_nxt;
  logic [23:0] lane_cnt [sspt_pkg::LANES];
  logic [7:0] lane_pass;
  logic test_clear;
  logic pclk_en;
  logic [7:0] req_len;
  logic [7:0] err_len;
  logic loss_low;
  logic [23:0] sel_cnt;

  // ==========================================================================
  // Pulse length in mclk cycles from a length in octets, rounded up
  function automatic logic [7:0] octets_to_mclk(input logic [7:0] octets);
    logic [8:0] sum;
    sum = {1'b0, octets} + 9'h001;
    return sum[8:1];
  endfunction

  // Field value to added octets, one parallel cycle per step
  function automatic logic [7:0] steps_to_octets(input logic [3:0] steps);
    return 8'(steps) * 8'(sspt_pkg::OCTETS_PER_PCLK);
  endfunction

  assign test_clear = st_r.ctrl[sspt_pkg::CLEAR_BIT];
  assign pclk_en = st_r.pclk_ph;
  assign sel_cnt = lane_cnt[st_r.ctrl[sspt_pkg::LANE_SEL_LSB +: 3]];

  // ==========================================================================
  // Lane checkers; gating of a lane is modelled as its enable
  for (genvar i = 0; i < sspt_pkg::LANES; i++) begin : g_lane
    sspt_lane_chk u_chk (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clear(test_clear),
      .active(st_r.ungate[i] && (st_r.tst == sspt_pkg::TST_RUN)),
      .seq_sel(st_r.ctrl[sspt_pkg::SEQ_SEL_LSB +: 2]),
      .rx_bit(lane_bits[i]),
      .thr(st_r.thr),
      .err_cnt(lane_cnt[i]),
      .pass(lane_pass[i])
    );
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    // Error pulse is one mclk (half parallel cycle) plus two per step
    err_len = 8'h01 + 8'(sspt_pkg::MCLK_PER_PCLK) * 8'(st_r.durs[sspt_pkg::ERR_DUR_LSB +: 4]);
    req_len = octets_to_mclk(8'(sspt_pkg::FRAMES_PER_REQ * sspt_pkg::FRAME_OCTETS)
      + 8'(sspt_pkg::REQ_EXTRA_OCTETS)
      + steps_to_octets(st_r.durs[sspt_pkg::REQ_DUR_LSB +: 4]));
    loss_low = (loss_in.frame_loss && !st_r.masks[sspt_pkg::MASK_FRAME_BIT])
      || (loss_in.mframe_loss && !st_r.masks[sspt_pkg::MASK_MFRAME_BIT]);

    // Parallel clock enable, every second mclk
    st_nxt.pclk_ph = !st_r.pclk_ph;

    // Multiframe period in parallel cycles, saturating so a slow tick shows max
    if (lmfc_tick) begin
      st_nxt.mf_period = st_r.mf_cnt;
      st_nxt.mf_cnt = '0;
    end else if (pclk_en && st_r.mf_cnt != 8'hff) begin
      st_nxt.mf_cnt = st_r.mf_cnt + 8'h01;
    end

    // Sync low pulses: a new pulse only lengthens, never cuts, one in flight
    if (st_r.pulse != 8'h00) begin
      st_nxt.pulse = st_r.pulse - 8'h01;
    end
    if (sync_req && req_len > st_nxt.pulse) begin
      st_nxt.pulse = req_len;
    end
    if (err_report && err_len > st_nxt.pulse) begin
      st_nxt.pulse = err_len;
    end
    // Unmasked loss holds the output low for as long as it lasts
    st_nxt.sync_n = (st_nxt.pulse == 8'h00) && !loss_low;

    // Test state machine; clear wins over run
    unique case (st_r.tst)
      sspt_pkg::TST_IDLE: begin
        if (st_r.ctrl[sspt_pkg::RUN_BIT] && !test_clear) begin
          st_nxt.tst = sspt_pkg::TST_RUN;
        end
      end
      sspt_pkg::TST_RUN: begin
        if (!st_r.ctrl[sspt_pkg::RUN_BIT] || test_clear) begin
          st_nxt.tst = sspt_pkg::TST_IDLE;
        end
      end
      default: st_nxt.tst = sspt_pkg::TST_IDLE;
    endcase

    // Lane clocks follow their enable bits one to one
    st_nxt.ungate = st_r.clk_en;

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        sspt_pkg::ADDR_SYNC_MASKS: st_nxt.masks = reg_wdata & sspt_pkg::SYNC_MASKS_WMASK;
        sspt_pkg::ADDR_SYNC_DURS: st_nxt.durs = reg_wdata;
        sspt_pkg::ADDR_TEST_CLK_EN: st_nxt.clk_en = reg_wdata;
        sspt_pkg::ADDR_TEST_CTRL: st_nxt.ctrl = reg_wdata & sspt_pkg::TEST_CTRL_WMASK;
        sspt_pkg::ADDR_THR_LO: st_nxt.thr[7:0] = reg_wdata;
        sspt_pkg::ADDR_THR_MID: st_nxt.thr[15:8] = reg_wdata;
        sspt_pkg::ADDR_THR_HI: st_nxt.thr[23:16] = reg_wdata;
        default: ;  // Read-only and unmapped addresses ignore writes
      endcase
    end

    // Register reads, answered the next cycle; unmapped reads zero
    if (reg_rd) begin
      unique case (reg_addr)
        sspt_pkg::ADDR_SYNC_MASKS: st_nxt.rdata = st_r.masks;
        sspt_pkg::ADDR_SYNC_DURS: st_nxt.rdata = st_r.durs;
        sspt_pkg::ADDR_MF_PERIOD: st_nxt.rdata = st_r.mf_period;
        sspt_pkg::ADDR_TEST_CLK_EN: st_nxt.rdata = st_r.clk_en;
        sspt_pkg::ADDR_TEST_CTRL: st_nxt.rdata = st_r.ctrl;
        sspt_pkg::ADDR_THR_LO: st_nxt.rdata = st_r.thr[7:0];
        sspt_pkg::ADDR_THR_MID: st_nxt.rdata = st_r.thr[15:8];
        sspt_pkg::ADDR_THR_HI: st_nxt.rdata = st_r.thr[23:16];
        sspt_pkg::ADDR_CNT_LO: st_nxt.rdata = sel_cnt[7:0];
        sspt_pkg::ADDR_CNT_MID: st_nxt.rdata = sel_cnt[15:8];
        sspt_pkg::ADDR_CNT_HI: st_nxt.rdata = sel_cnt[23:16];
        sspt_pkg::ADDR_PASS: st_nxt.rdata = lane_pass;
        default: st_nxt.rdata = sspt_pkg::RST_BYTE;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r.masks <= sspt_pkg::RST_BYTE;
      st_r.durs <= sspt_pkg::RST_BYTE;
      st_r.clk_en <= sspt_pkg::RST_BYTE;
      st_r.ctrl <= sspt_pkg::RST_BYTE;
      st_r.thr <= sspt_pkg::RST_THR;
      st_r.tst <= sspt_pkg::TST_IDLE;
      st_r.pclk_ph <= 1'b0;
      st_r.mf_cnt <= sspt_pkg::RST_BYTE;
      st_r.mf_period <= sspt_pkg::RST_BYTE;
      st_r.pulse <= sspt_pkg::RST_BYTE;
      st_r.sync_n <= 1'b1;
      st_r.rdata <= sspt_pkg::RST_BYTE;
      st_r.ungate <= sspt_pkg::RST_BYTE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign sync_out_n = st_r.sync_n;
  assign lane_test_clk_en = st_r.ungate;
endmodule
`default_nettype wire

// *** testbench/sspt_top_monitor.sv ***
/*
  Checker of sync output, lane clock enables and register port timing.
  Bound to sspt_top; sees its ports only, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sspt_monitor (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire sspt_pkg::sspt_loss_t loss_in,
  input wire logic sync_req,
  input wire logic err_report,
  input wire logic lmfc_tick,
  input wire logic sync_out_n,
  input wire logic [7:0] lane_test_clk_en
);
  // ==========================================================
  // Helpers
  logic [2:0] msk_r; // Copy of the loss masks
  logic unmapped; // Address outside the map
  logic en_wr; // Write to the lane clock enables
  assign unmapped = reg_addr < 12'h311 || reg_addr > 12'h31d || reg_addr == 12'h314;
  assign en_wr = reg_wr && reg_addr == sspt_pkg::ADDR_TEST_CLK_EN;
  // Copy follows writes on the same edge as the real register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      msk_r <= 3'h0;
    end else if (reg_wr && reg_addr == sspt_pkg::ADDR_SYNC_MASKS) begin
      msk_r <= reg_wdata[2:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Assertions
  reset_values_a: assert property ($fell(sys_rst) |-> sync_out_n && lane_test_clk_en == 8'h00 && reg_rdata == 8'h00)
    else $error("outputs off reset value");
  clk_copy_a: assert property (en_wr |=> ##1 lane_test_clk_en == $past(reg_wdata, 2))
    else $error("lane clock enable not copied");
  clk_hold_a: assert property ($changed(lane_test_clk_en) |-> $past(en_wr, 2))
    else $error("lane clock enable moved alone");
  unmapped_zero_a: assert property (reg_rd && unmapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without read");
  err_low_a: assert property (err_report |=> !sync_out_n)
    else $error("no low after error report");
  req_low_a: assert property (sync_req |=> !sync_out_n [*7])
    else $error("request pulse too short");
  low_cause_a: assert property ($fell(sync_out_n) |-> $past(err_report || sync_req || (|loss_in)))
    else $error("sync low without cause");
  frame_loss_a: assert property (loss_in.frame_loss && !msk_r[0] |=> !sync_out_n)
    else $error("frame loss not reported");
  mframe_loss_a: assert property (loss_in.mframe_loss && !msk_r[2] |=> !sync_out_n)
    else $error("multiframe loss not reported");
  cover property (err_report ##1 !sync_out_n);
  cover property (sync_req ##8 sync_out_n);
  cover property (lmfc_tick);
endmodule
bind sspt_top sspt_monitor u_monitor (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loss_in(loss_in), .sync_req(sync_req),
  .err_report(err_report), .lmfc_tick(lmfc_tick), .sync_out_n(sync_out_n), .lane_test_clk_en(lane_test_clk_en));
`default_nettype wire

// *** testbench/sspt_lane_src.sv ***
/*
  Far-end lane source: the selected sequence on all eight lanes,
  one flip input per lane for error injection. Runs on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module sspt_lane_src (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [1:0] seq_sel,
  input wire logic [7:0] flip,
  output logic [7:0] lane_bits
);
  logic [30:0] hist_r; // Last sent bits, bit 0 newest
  logic nb; // Next bit; code 11 falls back to the 7-bit taps
  // Next bit from the taps of the chosen sequence
  always_comb begin
    case (seq_sel)
      sspt_pkg::SEQ_PRBS15: nb = hist_r[14] ^ hist_r[13];
      sspt_pkg::SEQ_PRBS31: nb = hist_r[30] ^ hist_r[27];
      default: nb = hist_r[6] ^ hist_r[5];
    endcase
  end
  // All ones at reset so no pattern can lock at zero
  always_ff @(posedge mclk) begin
    hist_r <= sys_rst ? 31'h7fffffff : {hist_r[29:0], nb};
  end
  assign lane_bits = {8{hist_r[0]}} ^ flip;
endmodule
`default_nettype wire

// *** testbench/test_serdes_sync_and_prbs_test.sv ***
/*
  Register-level tests of sync pulses, loss masks, period and lane test.
  Assumes sspt_top, the lane source and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module test_serdes_sync_and_prbs_test;
  logic mclk, sync_out_n;
  logic sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sync_req = 1'b0, err_report = 1'b0, lmfc_tick = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, flip = 8'h00, reg_rdata, lane_bits, lane_test_clk_en;
  logic [1:0] seq = 2'h0;
  sspt_pkg::sspt_loss_t loss_in = '0;
  int failures = 0, samples_checked = 0, cycles = 0, n, k;
  logic [7:0] dur_tab [3] = '{8'h00, 8'h3a, 8'hf1};
  logic [19:0] rst_tab [7] = '{20'h31100, 20'h31200, 20'h31300, 20'h31500, 20'h31600, 20'h31dff, 20'h31400};
  sspt_top dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loss_in(loss_in), .sync_req(sync_req), .err_report(err_report),
    .lmfc_tick(lmfc_tick), .lane_bits(lane_bits), .sync_out_n(sync_out_n), .lane_test_clk_en(lane_test_clk_en));
  sspt_lane_src far_end (.mclk(mclk), .sys_rst(sys_rst), .seq_sel(seq), .flip(flip), .lane_bits(lane_bits));
  // ==========================================================
  // Clock, timeout and tasks
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Whole run needs some eleven hundred cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      end_of_test();
    end
  end
  // Inputs always change 1 ns after an edge
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    tick(1);
    cmp($sformatf("reg %h", a), exp, reg_rdata);
  endtask
  // Event pulse, then count the cycles of low sync output
  task automatic pulse_len(input logic is_req, input int exp);
    sync_req = is_req;
    err_report = !is_req;
    tick(1);
    sync_req = 1'b0;
    err_report = 1'b0;
    n = 0;
    while (sync_out_n === 1'b0 && n < 200) begin
      n++;
      tick(1);
    end
    cmp("sync low cycles", exp[7:0], n[7:0]);
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    tick(3);
    sys_rst = 1'b0;
    foreach (rst_tab[i]) rd(rst_tab[i][19:8], rst_tab[i][7:0]);
    wr(12'h311, 8'hff);
    rd(12'h311, 8'h07);
    wr(12'h313, 8'h55);
    rd(12'h313, 8'h00);
    rd(12'h400, 8'h00);
    $display("Test registers done");
    // Error pulse is 1 + 2 * field; request is seven plus 2 * field
    foreach (dur_tab[i]) begin
      wr(12'h312, dur_tab[i]);
      pulse_len(1'b0, 1 + 2 * dur_tab[i][7:4]);
      pulse_len(1'b1, 7 + 2 * dur_tab[i][3:0]);
    end
    // Odd bit masks frame or multiframe loss; even case masks the other
    for (int i = 0; i < 4; i++) begin
      wr(12'h311, (i[0] ^ i[1]) ? 8'h01 : 8'h04);
      loss_in = i[1] ? 2'b01 : 2'b10;
      tick(2);
      cmp("sync under loss", {7'h00, i[0]}, {7'h00, sync_out_n});
      loss_in = 2'b00;
      tick(2);
    end
    // Ticks 21 mclk apart span exactly ten parallel cycles
    lmfc_tick = 1'b1;
    tick(1);
    lmfc_tick = 1'b0;
    tick(20);
    lmfc_tick = 1'b1;
    tick(1);
    lmfc_tick = 1'b0;
    rd(12'h313, 8'h0a);
    $display("Test sync done");
    wr(12'h317, 8'h03);
    rd(12'h317, 8'h03);
    // One flipped bit gives three mismatches in a self-synchronising checker
    for (int s = 0; s < 4; s++) begin
      k = 2 * s;
      seq = s[1:0];
      wr(12'h315, 8'h01 << k);
      cmp("clock enables", 8'h01 << k, lane_test_clk_en);
      wr(12'h316, {1'b0, k[2:0], s[1:0], 2'b10});
      tick(40);
      flip = 8'h03 << k;
      tick(1);
      flip = 8'h00;
      tick(40);
      wr(12'h316, {1'b0, k[2:0], s[1:0], 2'b00});
      flip = 8'h01 << k;
      tick(1);
      flip = 8'h00;
      tick(40);
      rd(12'h31a, s == 3 ? 8'h00 : 8'h03);
      rd(12'h31b, 8'h00);
      rd(12'h31c, 8'h00);
      rd(12'h31d, s == 3 ? 8'hff : ~(8'h01 << k));
      wr(12'h316, {1'b0, k[2:0], s[1:0], 2'b01});
      rd(12'h31a, 8'h00);
      rd(12'h31d, 8'hff);
    end
    $display("Test lane sequence done");
    // Held inversion on lane 0: 300 flipped bits give 300 counted mismatches, threshold 301 keeps the lane passing
    seq = 2'h0;
    wr(12'h317, 8'h2d);
    wr(12'h318, 8'h01);
    rd(12'h318, 8'h01);
    wr(12'h315, 8'h01);
    wr(12'h316, 8'h02);
    tick(40);
    flip = 8'h01;
    tick(300);
    flip = 8'h00;
    tick(20);
    wr(12'h316, 8'h00);
    rd(12'h31a, 8'h2c);
    rd(12'h31b, 8'h01);
    rd(12'h31c, 8'h00);
    rd(12'h31d, 8'hff);
    $display("Test long count done");
    end_of_test();
  end
endmodule
`default_nettype wire
